// ==== rtl/pacs_pkg.sv ====
/*
 * constants and types for the peak adc conversion sequencer:
 * timing, register offsets, field positions, state encoding.
 * assumes a 100 MHz system clock.
 */
package pacs_pkg;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_NS = 10;
   localparam int SETTLE_NS = 600;
   localparam int DIGIT_NS = 6000;
   localparam int CLEAR_NS = 600;
   localparam int CONV_FULL_NS = 5700;
   localparam int CONV_HALF_NS = 2800;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int DIGIT_CYC = DIGIT_NS / CLK_NS;
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;

   // ***************************************************
   // register map and fields
   // ***************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SLIDE_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] THR_BASE = 8'h80;
   localparam int CTRL_SLIDE_BIT = 0;
   localparam int CTRL_UNDER_BIT = 1;
   localparam int CTRL_OVF_BIT = 2;
   localparam int CTRL_FINE_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int THR_KILL_BIT = 8;
   localparam logic [8:0] THR_RST = 9'h000;
   localparam int WORD_OVF_BIT = 12;
   localparam int WORD_BELOW_BIT = 13;
   localparam logic [11:0] VALID_MAX = 12'h0F00;

   // sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_ACQ, ST_SETTLE, ST_CONV, ST_CLEAR} pacs_state_t;

endpackage

// ==== rtl/pacs_sequencer.sv ====
/*
 * peak adc conversion sequencer with its event fifo.
 * assumes adc results and overflow flags are synchronous to clk_i and
 * valid at the end of each conversion step; gate_i is an async pin.
 */
`timescale 1ns/10ps

// ***************************************************
// fifo
// ***************************************************
module pacs_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // read side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   // handshakes
   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_r[rp_r];
   assign count_o = cnt_r;

   // storage
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ***************************************************
// sequencer top
// ***************************************************
module pacs_sequencer #(
   parameter int NCH = 32,
   parameter int CONV_NS = (NCH == 32) ? pacs_pkg::CONV_FULL_NS : pacs_pkg::CONV_HALF_NS,
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   // analogue front end
   input wire logic gate_i,
   output logic acq_o,
   output logic clear_o,
   output logic [11:0] slide_o,
   // converters
   output logic adc_start_o,
   output logic [$clog2(NCH/2)-1:0] mux_sel_o,
   input wire logic [11:0] adc_a_i,
   input wire logic [11:0] adc_b_i,
   input wire logic adc_ovf_a_i,
   input wire logic adc_ovf_b_i,
   // event memory stream
   output logic ev_valid_o,
   input wire logic ev_ready_i,
   output logic [20:0] ev_data_o,
   output logic busy_o
);
   localparam int HALF = NCH / 2;
   localparam int SW = $clog2(HALF);
   localparam int CW = $clog2(NCH);
   localparam int STEP_CYC = (CONV_NS / pacs_pkg::CLK_NS) / HALF;

   pacs_pkg::pacs_state_t state_r;
   logic [3:0] ctrl_r;
   logic [8:0] thr_r [NCH];
   logic [11:0] slide_r;
   logic g1_r, g2_r, g3_r;
   logic [9:0] tmr_r;
   logic [9:0] dig_r;
   logic [7:0] cnt_r;
   logic [SW-1:0] step_r;
   logic sub_r, done_r;
   logic out_vld_r;
   logic [20:0] out_word_r;
   logic fifo_ready;
   logic [$clog2(FIFO_DEPTH):0] fifo_cnt;
   logic stall, capture, ack_r;
   logic [31:0] dat_r;
   logic [CW-1:0] ch;
   logic [11:0] raw, corr;
   logic ovf, below, keep;
   logic [20:0] word;

   // ***************************************************
   // gate synchroniser
   // ***************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         g1_r <= 1'b0;
         g2_r <= 1'b0;
         g3_r <= 1'b0;
      end
      else
      begin
         g1_r <= gate_i;
         g2_r <= g1_r;
         g3_r <= g2_r;
      end
   end

   // ***************************************************
   // sequencer
   // ***************************************************
   assign stall = out_vld_r && !fifo_ready;
   assign capture = (state_r == pacs_pkg::ST_CONV) && !stall && !done_r
      && (cnt_r == 8'(STEP_CYC - 1));

   // phase control: idle, acquire, settle, convert, clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= pacs_pkg::ST_IDLE;
         tmr_r <= '0;
      end
      else
      begin
         unique case (state_r)
            pacs_pkg::ST_IDLE:
            begin
               if (g2_r && !g3_r)
               begin
                  state_r <= pacs_pkg::ST_ACQ;
               end
            end
            pacs_pkg::ST_ACQ:
            begin
               tmr_r <= '0;
               if (!g2_r)
               begin
                  state_r <= pacs_pkg::ST_SETTLE;
               end
            end
            pacs_pkg::ST_SETTLE:
            begin
               tmr_r <= tmr_r + 1'b1;
               if (tmr_r == 10'(pacs_pkg::SETTLE_CYC - 1))
               begin
                  state_r <= pacs_pkg::ST_CONV;
               end
            end
            pacs_pkg::ST_CONV:
            begin
               tmr_r <= '0;
               if (!stall && done_r && dig_r >= 10'(pacs_pkg::DIGIT_CYC - 1))
               begin
                  state_r <= pacs_pkg::ST_CLEAR;
               end
            end
            pacs_pkg::ST_CLEAR:
            begin
               tmr_r <= tmr_r + 1'b1;
               if (tmr_r == 10'(pacs_pkg::CLEAR_CYC - 1))
               begin
                  state_r <= pacs_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // conversion stepping; stalls while the fifo refuses a result
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_r != pacs_pkg::ST_CONV)
      begin
         dig_r <= '0;
         cnt_r <= '0;
         step_r <= '0;
         sub_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (!stall)
      begin
         dig_r <= dig_r + 1'b1;
         if (!capture)
         begin
            cnt_r <= done_r ? cnt_r : cnt_r + 1'b1;
         end
         else if (!sub_r)
         begin
            sub_r <= 1'b1;
         end
         else
         begin
            sub_r <= 1'b0;
            cnt_r <= '0;
            if (step_r == SW'(HALF - 1))
            begin
               done_r <= 1'b1;
            end
            else
            begin
               step_r <= step_r + 1'b1;
            end
         end
      end
   end

   // one gate line for all channels; clear only after digitisation
   assign acq_o = (state_r == pacs_pkg::ST_ACQ);
   assign clear_o = (state_r == pacs_pkg::ST_CLEAR);
   assign busy_o = (state_r != pacs_pkg::ST_IDLE);
   assign mux_sel_o = step_r;
   assign adc_start_o = (state_r == pacs_pkg::ST_CONV) && !done_r && cnt_r == '0 && !sub_r
      && !stall; // one pulse per step, none while stalled
   assign slide_o = slide_r;

   // sliding offset moves once per event; zero when disabled
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !ctrl_r[pacs_pkg::CTRL_SLIDE_BIT])
      begin
         slide_r <= '0;
      end
      else if (clear_o && tmr_r == '0)
      begin
         slide_r <= {4'h0, slide_r[7:0] + 8'h01};
      end
   end

   // ***************************************************
   // result filter
   // ***************************************************
   always_comb
   begin
      ch = sub_r ? CW'(step_r) + CW'(HALF) : CW'(step_r);
      raw = sub_r ? adc_b_i : adc_a_i;
      ovf = sub_r ? adc_ovf_b_i : adc_ovf_a_i;
      corr = (raw >= slide_r) ? raw - slide_r : 12'h000;
      if (ctrl_r[pacs_pkg::CTRL_SLIDE_BIT] && corr > pacs_pkg::VALID_MAX)
      begin
         ovf = 1'b1;
      end
      if (ctrl_r[pacs_pkg::CTRL_FINE_BIT])
      begin
         below = corr < {3'h0, thr_r[ch][7:0], 1'b0};
      end
      else
      begin
         below = corr < {thr_r[ch][7:0], 4'h0};
      end
      keep = !thr_r[ch][pacs_pkg::THR_KILL_BIT]
         && (!ovf || ctrl_r[pacs_pkg::CTRL_OVF_BIT])
         && (!below || ctrl_r[pacs_pkg::CTRL_UNDER_BIT]);
      word = {5'(ch), 2'b00, below, ovf, corr};
   end

   // result register in front of the fifo
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_vld_r <= 1'b0;
         out_word_r <= '0;
      end
      else if (capture)
      begin
         out_vld_r <= keep;
         out_word_r <= word;
      end
      else if (fifo_ready)
      begin
         out_vld_r <= 1'b0;
      end
   end

   pacs_fifo #(.WIDTH(21), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(out_vld_r),
      .in_ready_o(fifo_ready),
      .in_data_i(out_word_r),
      .out_valid_o(ev_valid_o),
      .out_ready_i(ev_ready_i),
      .out_data_o(ev_data_o),
      .count_o(fifo_cnt)
   );

   // ***************************************************
   // wishbone registers
   // ***************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         dat_r <= '0;
         ctrl_r <= pacs_pkg::CTRL_RST;
         for (int i = 0; i < NCH; i++)
         begin
            thr_r[i] <= pacs_pkg::THR_RST;
         end
      end
      else
      begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
         dat_r <= '0;
         if (wb_cyc_i && wb_stb_i && !ack_r)
         begin
            if (wb_adr_i >= pacs_pkg::THR_BASE && {1'b0, wb_adr_i[7:2]} < 7'(32 + NCH))
            begin
               dat_r <= {23'h0, thr_r[wb_adr_i[CW+1:2]]};
               if (wb_we_i && wb_sel_i[0])
               begin
                  thr_r[wb_adr_i[CW+1:2]][7:0] <= wb_dat_i[7:0];
               end
               if (wb_we_i && wb_sel_i[1])
               begin
                  thr_r[wb_adr_i[CW+1:2]][8] <= wb_dat_i[8];
               end
            end
            else if (wb_adr_i == pacs_pkg::CTRL_OFS)
            begin
               dat_r <= {28'h0, ctrl_r};
               if (wb_we_i && wb_sel_i[0])
               begin
                  ctrl_r <= wb_dat_i[3:0];
               end
            end
            else if (wb_adr_i == pacs_pkg::SLIDE_OFS)
            begin
               dat_r <= {20'h0, slide_r};
            end
            else if (wb_adr_i == pacs_pkg::STAT_OFS)
            begin
               dat_r <= {24'h0, 1'b0, 4'(fifo_cnt), state_r};
            end
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   acq_from_idle_a: assert property ($rose(acq_o) |-> $past(state_r) == pacs_pkg::ST_IDLE)
      else $error("acquisition entered from a non-idle state");
   settle_len_a: assert property ($fell(state_r == pacs_pkg::ST_SETTLE) |->
      $past(tmr_r) == 10'(pacs_pkg::SETTLE_CYC - 1) && state_r == pacs_pkg::ST_CONV)
      else $error("settle phase length wrong");
   digit_len_a: assert property ($rose(clear_o) |->
      $past(dig_r) >= 10'(pacs_pkg::DIGIT_CYC - 1) && $past(done_r))
      else $error("clear before digitisation finished");
   clear_len_a: assert property ($rose(clear_o) |-> clear_o[*8] ##0
      (tmr_r == 10'd7))
      else $error("clear phase too short");
   clear_end_a: assert property ($fell(clear_o) |->
      $past(tmr_r) == 10'(pacs_pkg::CLEAR_CYC - 1) && state_r == pacs_pkg::ST_IDLE)
      else $error("clear phase end wrong");
   hold_quiet_a: assert property (state_r inside {pacs_pkg::ST_SETTLE, pacs_pkg::ST_CONV}
      |-> !acq_o && !clear_o)
      else $error("held peaks disturbed");
   start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
      else $error("conversion start held high");
   kill_drop_a: assert property (capture && thr_r[ch][pacs_pkg::THR_KILL_BIT] |=> !out_vld_r)
      else $error("killed channel stored");
   ovf_keep_a: assert property (capture && ovf && !ctrl_r[pacs_pkg::CTRL_OVF_BIT] |=> !out_vld_r)
      else $error("overflow stored while dropping");
   below_keep_a: assert property (capture && keep && below |=>
      out_vld_r && out_word_r[pacs_pkg::WORD_BELOW_BIT])
      else $error("below-limit flag missing");
   range_a: assert property (capture && ctrl_r[pacs_pkg::CTRL_SLIDE_BIT]
      && corr > pacs_pkg::VALID_MAX
      |=> !out_vld_r || out_word_r[pacs_pkg::WORD_OVF_BIT])
      else $error("out of range value not flagged");

   event_c: cover property ($rose(clear_o));
   stall_c: cover property (stall && state_r == pacs_pkg::ST_CONV);
   below_c: cover property (capture && keep && below);
   ovf_c: cover property (capture && keep && ovf);
endmodule

// ==== verif/pacs_front_model.sv ====
/* peak-hold stages and two converters facing the sequencer.
   assumes the sequencer outputs are synchronous to clk_i. */
`timescale 1ns/10ps
module pacs_front_model #(
   parameter int NCH = 32,
   parameter int LAT = 30
) (
   // clock
   input wire logic clk_i,
   // from sequencer
   input wire logic acq_i,
   input wire logic clear_i,
   input wire logic [11:0] slide_i,
   input wire logic start_i,
   input wire logic [$clog2(NCH/2)-1:0] sel_i,
   // converter results
   output logic [11:0] a_o,
   output logic [11:0] b_o,
   output logic ovf_a_o,
   output logic ovf_b_o
);
   int pk[NCH];
   int held[NCH];
   int wait_c = 0;

   // clip to converter range, flag overflow
   function automatic logic [12:0] cv(input int v);
      return (v > 4095) ? 13'h1_FFF : 13'(v);
   endfunction

   initial
   begin
      {ovf_a_o, a_o, ovf_b_o, b_o} = 26'h000_0000;
      foreach (pk[i]) pk[i] = 0;
      foreach (held[i]) held[i] = 0;
   end

   // peaks follow inputs while acquiring, then hold until discharge
   always @(posedge clk_i)
   begin
      for (int i = 0; i < NCH; i++)
      begin
         if (clear_i)
            held[i] <= 0;
         else if (acq_i && pk[i] > held[i])
            held[i] <= pk[i];
      end
   end

   // slow answer; lines churn while a result is pending and during clear
   always @(posedge clk_i)
   begin
      if (start_i)
         wait_c <= LAT;
      else if (wait_c > 0)
         wait_c <= wait_c - 1;
      if (wait_c == 1)
      begin
         {ovf_a_o, a_o} <= cv(held[sel_i] + slide_i);
         {ovf_b_o, b_o} <= cv(held[sel_i + NCH/2] + slide_i);
      end
      else if (wait_c > 0 || clear_i)
      begin
         a_o <= ~a_o;
         b_o <= ~b_o;
      end
   end
endmodule

// ==== verif/testbench.sv ====
/* bench for the conversion sequencer: bus, gate, converters, stream.
   assumes the front end model beside it and a 100 MHz clock. */
`timescale 1ns/10ps
module testbench;
   localparam int NCH = 32;
   logic clk_i = 0;
   logic rst_i = 1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'hF;
   logic wb_we_i = 0;
   logic wb_cyc_i = 0;
   logic wb_stb_i = 0;
   logic gate_i = 0;
   logic ev_ready_i = 1;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, acq_o, clear_o, adc_start_o, ev_valid_o, busy_o;
   logic [11:0] slide_o, adc_a_i, adc_b_i;
   logic adc_ovf_a_i, adc_ovf_b_i;
   logic [3:0] mux_sel_o;
   logic [20:0] ev_data_o;
   logic [31:0] rd;
   logic [3:0] ctl = 4'h0;
   logic [8:0] thr[NCH];
   int err_total = 0;
   int total_checks = 0;
   int cyc_n = 0;

   // ******
   // clock, design, front end
   // ******
   always #5 clk_i = ~clk_i;

   pacs_sequencer #(.NCH(NCH)) dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
      .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .gate_i, .acq_o, .clear_o,
      .slide_o, .adc_start_o, .mux_sel_o, .adc_a_i, .adc_b_i, .adc_ovf_a_i, .adc_ovf_b_i,
      .ev_valid_o, .ev_ready_i, .ev_data_o, .busy_o);

   pacs_front_model #(.NCH(NCH)) fm (.clk_i, .acq_i(acq_o), .clear_i(clear_o),
      .slide_i(slide_o), .start_i(adc_start_o), .sel_i(mux_sel_o), .a_o(adc_a_i),
      .b_o(adc_b_i), .ovf_a_o(adc_ovf_a_i), .ovf_b_o(adc_ovf_b_i));

   // ******
   // reporting
   // ******
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk_in(input string what, input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi)
      begin
         err_total++;
         $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         err_total++;
         end_of_test();
      end
   end

   // ******
   // bus and stimulus helpers
   // ******
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // ack is sampled at a rising edge; the request is released right after it
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      chk("wb ack delay", 2, n);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic cfg(input logic [3:0] m);
      ctl = m;
      wb(1, pacs_pkg::CTRL_OFS, {28'h000_0000, m});
      wb(0, pacs_pkg::CTRL_OFS, 0);
      chk("ctrl", {28'h000_0000, m}, rd);
   endtask

   task automatic set_thr(input int ch, input logic [8:0] v);
      thr[ch] = v;
      wb(1, pacs_pkg::THR_BASE + 8'(4 * ch), {23'h00_0000, v});
   endtask

   // expected stream word and whether it is kept
   function automatic bit keep_w(input int ch, input int off, output logic [20:0] w);
      int s = fm.pk[ch] + off;
      int v;
      bit ovf, blw;
      ovf = s > 4095;
      v = (ovf ? 4095 : s) - off;
      ovf |= ctl[0] && v > 3840;
      blw = v < thr[ch][7:0] * (ctl[3] ? 2 : 16);
      w = {5'(ch), 2'b00, blw, ovf, 12'(v)};
      return !thr[ch][8] && (!ovf || ctl[2]) && (!blw || ctl[1]);
   endfunction

   // one gate, full sequence, stalled sink, all words judged
   task automatic run_event(input bit regate);
      int c = 0, t_acq = 0, t_st = 0, t_clr = 0, t_idle = 0;
      int n_st = 0, n_clr = 0, n_bad = 0, off = 0;
      bit done = 0;
      logic [20:0] q[$];
      logic [20:0] e[$];
      logic [20:0] w;
      @(posedge clk_i);
      gate_i <= 1'b1;
      while (!done && c < 3000)
      begin
         @(negedge clk_i);
         if (acq_o)
            t_acq = c;
         if (acq_o && n_st > 0)
            n_bad++;
         if (adc_start_o)
         begin
            if (n_st == 0)
               t_st = c;
            if (n_st == 0)
               off = slide_o;
            chk("mux step", n_st, mux_sel_o);
            n_st++;
         end
         if (clear_o && n_clr++ == 0)
            t_clr = c;
         if (n_clr > 0 && !busy_o && t_idle == 0)
            t_idle = c;
         if (ev_valid_o && ev_ready_i)
            q.push_back(ev_data_o);
         done = t_idle > 0 && !ev_valid_o;
         @(posedge clk_i);
         c++;
         gate_i <= c < 10 || (regate && c > 300 && c < 306);
         ev_ready_i <= c < 150 || c > 400;
      end
      chk_in("gate to acq", 10, 15, t_acq);
      chk_in("settle", 58, 64, t_st - t_acq);
      chk_in("digitise", 598, 1000, t_clr - t_st);
      chk("steps", NCH / 2, n_st);
      chk("clear len", 60, n_clr);
      chk("idle after clear", 60, t_idle - t_clr);
      chk("acq in conv", 0, n_bad);
      if (!ctl[0])
         chk("offset", 0, off);
      for (int k = 0; k < NCH; k++)
         if (keep_w(k % 2 * NCH / 2 + k / 2, off, w))
            e.push_back(w);
      chk("word count", e.size(), q.size());
      foreach (e[i]) chk("word", e[i], q[i]);
   endtask

   // ******
   // scenarios
   // ******
   task automatic t_reset();
      @(negedge clk_i);
      chk("idle outs", 0, {acq_o, clear_o, busy_o, ev_valid_o, slide_o});
      wb(0, pacs_pkg::CTRL_OFS, 0);
      chk("ctrl rst", 0, rd);
      wb(1, 8'h40, 32'hFFFF_FFFF);
      wb(0, 8'h40, 0);
      chk("unmapped", 0, rd);
      wb(0, pacs_pkg::THR_BASE + 8'h7C, 0);
      chk("thr rst", 0, rd);
      $display("test reset done");
   endtask

   task automatic t_plain();
      for (int i = 0; i < NCH; i++)
         fm.pk[i] = 64 + 127 * i;
      fm.pk[31] = 4095;
      cfg(4'h0);
      run_event(1);
      $display("test plain done");
   endtask

   task automatic t_filter();
      logic [3:0] md[3] = '{4'h0, 4'h6, 4'h8};
      set_thr(0, 9'h100);
      set_thr(1, 9'h010);
      set_thr(2, 9'h010);
      fm.pk[1] = 255;
      fm.pk[2] = 256;
      fm.pk[3] = 5000;
      foreach (md[m])
      begin
         cfg(md[m]);
         run_event(0);
      end
      $display("test filter done");
   endtask

   task automatic t_slide();
      logic [3:0] md[2] = '{4'h1, 4'h5};
      for (int i = 0; i < NCH; i++)
         fm.pk[i] = 3700 + i;
      fm.pk[4] = 3840;
      fm.pk[5] = 3841;
      fm.pk[6] = 4095;
      foreach (md[m])
      begin
         cfg(md[m]);
         run_event(0);
      end
      $display("test slide done");
   endtask

   // main sequence
   initial
   begin
      foreach (thr[i]) thr[i] = 9'h000;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_plain();
      t_filter();
      t_slide();
      end_of_test();
   end
endmodule
